/* rtl/adcctl_consts.svh */
// Constants for the converter control block
`ifndef ADCCTL_CONSTS_SVH
`define ADCCTL_CONSTS_SVH
// ----------------------------------------
// Clocking
// ----------------------------------------
`define ADCCTL_SYS_HZ        100000000
`define ADCCTL_OSC_HZ        1000000
`define ADCCTL_OSC_DIV       (`ADCCTL_SYS_HZ / `ADCCTL_OSC_HZ)
`define ADCCTL_MOD_DIV       4
// ----------------------------------------
// Data rates in samples per second
// ----------------------------------------
`define ADCCTL_SPS_0         8
`define ADCCTL_SPS_1         16
`define ADCCTL_SPS_2         32
`define ADCCTL_SPS_3         64
`define ADCCTL_SPS_4         128
`define ADCCTL_SPS_5         250
`define ADCCTL_SPS_6         475
`define ADCCTL_SPS_7         860
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCCTL_RST_INPUT     3'h0
`define ADCCTL_RST_RANGE     3'h2
`define ADCCTL_RST_RATE      3'h4
`define ADCCTL_FIXED_RANGE   3'h2
`define ADCCTL_RESULT_W      16
`endif

/* rtl/adcctl_pkg.sv */
// Types shared by the converter control block
package adcctl_pkg;
  // Operating states of the conversion sequencer
  typedef enum logic [1:0] {
    ADCCTL_ST_DOWN,
    ADCCTL_ST_CONV,
    ADCCTL_ST_STORE
  } adcctl_state_t;

  // Analog routing decided from the input field
  typedef struct packed {
    logic [1:0] pos_sel;   // Positive input index
    logic [1:0] neg_sel;   // Negative input index
    logic       neg_gnd;   // Negative tied to ground
  } adcctl_route_t;

  // Host configuration
  typedef struct packed {
    logic       one_shot;
    logic [2:0] input_select;
    logic [2:0] range_select;
    logic [2:0] rate_select;
  } adcctl_cfg_t;
endpackage

/* rtl/adcctl_filter.sv */
// Decimating filter: counts modulator ones over one conversion
`timescale 1ns/1ps
`default_nettype none
module adcctl_filter #(
  parameter int CW = 24
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          clr_i,      // Start of a conversion
  input  wire logic          mod_en_i,   // Modulator clock enable
  input  wire logic          bit_i,      // Synchronised bitstream
  output logic [CW-1:0]      ones_o,
  output logic [CW-1:0]      total_o
);
  // ----------------------------------------
  // Accumulators
  // ----------------------------------------
  // Ones density over the window is proportional to the input
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ones_o  <= '0;
      total_o <= '0;
    end else if (clr_i) begin
      ones_o  <= '0;
      total_o <= '0;
    end else if (mod_en_i) begin
      ones_o  <= ones_o + CW'(bit_i);
      total_o <= total_o + CW'(1);
    end
  end
endmodule
`default_nettype wire

/* rtl/adcctl_top.sv */
// Converter control: sequencing, routing, range, rate and result
// ----------------------------------------
// Summary of operation
// - one conversion per one-shot request
// - store result then power down
// - free-run restarts right after completion
// - free-run completes at programmed rate
// - result reads latest completed conversion
// - input field picks the measured pair
// - single-ended grounds negative input
// - modulator clock is oscillator divided four
// - range field selects six halving spans
// - step equals span over 2^16
// - no-gain variant fixes 2.048 V span
// - no-selector variant uses input 0 vs 1
// - filter decimates bitstream to proportional code
// - rate field selects eight data rates
// - conversion time is one over rate
// - one-shot mode waits for start bit
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_consts.svh"
module adcctl_top #(
  parameter bit HAS_GAIN = 1'b1,          // Range stage present
  parameter bit HAS_SEL  = 1'b1,          // Input selector present
  parameter int OSC_DIV  = `ADCCTL_OSC_DIV // Sys cycles per osc tick
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire adcctl_pkg::adcctl_cfg_t cfg_i,     // Host configuration
  input  wire logic                 start_status_bit_i, // Start pulse
  input  wire logic                 mod_bit_i,  // Modulator bitstream pin
  output logic [15:0]               result_o,   // Conversion register
  output logic                      busy_o,     // Conversion ongoing
  output logic                      done_o,     // Completion pulse
  output logic                      modulator_clock_o,
  output var adcctl_pkg::adcctl_route_t route_o,
  output logic [2:0]                full_scale_span_o
);
  // ----------------------------------------
  // Oscillator and modulator enables
  // ----------------------------------------
  logic [7:0] osc_cnt_r;   // Sys to 1 MHz divider
  logic       osc_en;      // 1 MHz tick
  logic [1:0] mod_cnt_r;   // Osc to 250 kHz divider
  logic       mod_en;      // 250 kHz tick
  assign osc_en = (osc_cnt_r == 8'(OSC_DIV - 1));
  assign mod_en = osc_en && (mod_cnt_r == 2'(`ADCCTL_MOD_DIV - 1));

  // Divide by four of the oscillator tick
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt_r <= 8'h00;
      mod_cnt_r <= 2'h0;
    end else begin
      osc_cnt_r <= osc_en ? 8'h00 : osc_cnt_r + 8'h01;
      if (osc_en)
        mod_cnt_r <= mod_cnt_r + 2'h1;
    end
  end

  // Visible modulator clock, 50 % duty
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      modulator_clock_o <= 1'b0;
    else if (osc_en)
      modulator_clock_o <= (mod_cnt_r == 2'h1) || (mod_cnt_r == 2'h2);
  end

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic bit_s1_r;  // First stage, read only by second
  logic bit_s2_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_s1_r <= 1'b0;
      bit_s2_r <= 1'b0;
    end else begin
      bit_s1_r <= mod_bit_i;
      bit_s2_r <= bit_s1_r;
    end
  end

  // ----------------------------------------
  // Rate: oscillator ticks per conversion
  // ----------------------------------------
  logic [17:0] conv_len;   // Osc ticks in one conversion
  always_comb begin
    unique case (cfg_i.rate_select)
      3'h0: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_0);
      3'h1: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_1);
      3'h2: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_2);
      3'h3: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_3);
      3'h4: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_4);
      3'h5: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_5);
      3'h6: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_6);
      3'h7: conv_len = 18'(`ADCCTL_OSC_HZ / `ADCCTL_SPS_7);
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  adcctl_pkg::adcctl_state_t state_r;
  logic [17:0] tick_r;        // Osc ticks elapsed in conversion
  logic        pend_r;        // Start request latched
  logic        conv_end;      // Window reached, or passed after a rate cut
  assign conv_end = (state_r == adcctl_pkg::ADCCTL_ST_CONV) && osc_en &&
                    (tick_r >= conv_len - 18'h1);

  // Start requests while busy are dropped
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      pend_r <= 1'b0;
    else if (state_r != adcctl_pkg::ADCCTL_ST_DOWN)
      pend_r <= 1'b0;
    else if (start_status_bit_i)
      pend_r <= 1'b1;
  end

  // State transitions
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= adcctl_pkg::ADCCTL_ST_DOWN;
      tick_r  <= 18'h0;
    end else begin
      unique case (state_r)
        adcctl_pkg::ADCCTL_ST_DOWN: begin
          tick_r <= 18'h0;
          // Free-run leaves power-down at once
          if (!cfg_i.one_shot || pend_r)
            state_r <= adcctl_pkg::ADCCTL_ST_CONV;
        end
        adcctl_pkg::ADCCTL_ST_CONV: begin
          if (conv_end)
            state_r <= adcctl_pkg::ADCCTL_ST_STORE;
          else if (osc_en)
            tick_r <= tick_r + 18'h1;
        end
        adcctl_pkg::ADCCTL_ST_STORE: begin
          tick_r <= 18'h0;
          if (cfg_i.one_shot)
            state_r <= adcctl_pkg::ADCCTL_ST_DOWN;
          else
            state_r <= adcctl_pkg::ADCCTL_ST_CONV;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Filter and result
  // ----------------------------------------
  logic [23:0] ones;
  logic [23:0] total;
  adcctl_filter #(.CW(24)) u_filter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .clr_i     (state_r == adcctl_pkg::ADCCTL_ST_DOWN ||
                state_r == adcctl_pkg::ADCCTL_ST_STORE),
    .mod_en_i  (mod_en && state_r == adcctl_pkg::ADCCTL_ST_CONV),
    .bit_i     (bit_s2_r),
    .ones_o    (ones),
    .total_o   (total)
  );

  // Signed code = (2*ones - total) * 2^15 / total; the divide is a
  // slow combinational path, tolerable since it is used once per
  // conversion but it would need pipelining at higher clocks
  logic signed [41:0] code_wide;
  logic [15:0]        code;
  always_comb begin
    code_wide = 42'sd0;
    if (total != 24'h0)
      code_wide = ($signed({17'h0, ones, 1'b0}) - $signed({18'h0, total}))
                  * 42'sd32768 / $signed({18'h0, total});
    if (code_wide > 42'sd32767)
      code = 16'h7fff;
    else if (code_wide < -42'sd32768)
      code = 16'h8000;
    else
      code = code_wide[15:0];
  end

  // Result register updates only at completion
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      result_o <= 16'h0000;
    else if (state_r == adcctl_pkg::ADCCTL_ST_STORE)
      result_o <= code;
  end

  // Status outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= conv_end;
      busy_o <= (state_r != adcctl_pkg::ADCCTL_ST_DOWN);
    end
  end

  // ----------------------------------------
  // Input routing and range
  // ----------------------------------------
  adcctl_pkg::adcctl_route_t route_nxt;
  always_comb begin
    route_nxt = '{pos_sel: 2'h0, neg_sel: 2'h1, neg_gnd: 1'b0};
    if (HAS_SEL) begin
      unique case (cfg_i.input_select)
        3'h0: route_nxt = '{2'h0, 2'h1, 1'b0};
        3'h1: route_nxt = '{2'h0, 2'h3, 1'b0};
        3'h2: route_nxt = '{2'h1, 2'h3, 1'b0};
        3'h3: route_nxt = '{2'h2, 2'h3, 1'b0};
        3'h4: route_nxt = '{2'h0, 2'h0, 1'b1};
        3'h5: route_nxt = '{2'h1, 2'h0, 1'b1};
        3'h6: route_nxt = '{2'h2, 2'h0, 1'b1};
        3'h7: route_nxt = '{2'h3, 2'h0, 1'b1};
      endcase
    end // Without a selector the default pair stays
  end

  // Routing and span held in flops for clean outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_o           <= '{2'h0, 2'h1, 1'b0};
      full_scale_span_o <= `ADCCTL_FIXED_RANGE;
    end else begin
      route_o <= route_nxt;
      if (!HAS_GAIN)
        full_scale_span_o <= `ADCCTL_FIXED_RANGE;
      else if (cfg_i.range_select > 3'h5)
        full_scale_span_o <= 3'h5; // codes 6,7 alias 0.256 V
      else
        full_scale_span_o <= cfg_i.range_select;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [9:0] mod_gap_r;  // Sys cycles since the last modulator tick
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      mod_gap_r <= 10'h000;
    else
      mod_gap_r <= mod_en ? 10'h000 : mod_gap_r + 10'h001;
  end
  a_mod_div: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    mod_en == (mod_gap_r == 10'(`ADCCTL_MOD_DIV * OSC_DIV - 1)))
    else $error("modulator tick spacing wrong");
  a_store_oneshot: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_r == adcctl_pkg::ADCCTL_ST_STORE && cfg_i.one_shot) |=>
    state_r == adcctl_pkg::ADCCTL_ST_DOWN)
    else $error("one-shot did not power down");
  a_free_restart: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_r == adcctl_pkg::ADCCTL_ST_STORE && !cfg_i.one_shot) |=>
    state_r == adcctl_pkg::ADCCTL_ST_CONV)
    else $error("free-run did not restart");
  a_result_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    $past(state_r) != adcctl_pkg::ADCCTL_ST_STORE |-> $stable(result_o))
    else $error("result changed outside store");
  a_wait_start: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_r == adcctl_pkg::ADCCTL_ST_DOWN && cfg_i.one_shot && !pend_r)
    |=> state_r == adcctl_pkg::ADCCTL_ST_DOWN)
    else $error("one-shot left power-down unasked");
  a_done_store: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) done_o |-> state_r == adcctl_pkg::ADCCTL_ST_STORE)
    else $error("done without store");
  a_se_ground: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (HAS_SEL && cfg_i.input_select[2]) |=> route_o.neg_gnd)
    else $error("single-ended negative not grounded");
  a_span_max: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) ##1 full_scale_span_o <= 3'h5)
    else $error("span code out of range");
  c_oneshot: cover property (@(posedge clk_sys_i)
    done_o && cfg_i.one_shot);
  c_freerun: cover property (@(posedge clk_sys_i)
    done_o && !cfg_i.one_shot);
  c_se: cover property (@(posedge clk_sys_i) route_o.neg_gnd);
endmodule
`default_nettype wire

/* verification/adcctl_mod_model.sv */
// Behavioural modulator bitstream source for the converter bench
`timescale 1ns/1ps
`default_nettype none
module adcctl_mod_model (
  input  wire logic modulator_clock_i, // Sampling clock from the block
  input  wire logic level_i,           // Wanted ones density, 0 or 1
  output logic      bit_o              // Bitstream into the block
);
  // ----------------------------------------
  // Bitstream update
  // ----------------------------------------
  // Moves on the falling edge so the block never samples a changing bit
  initial bit_o = 1'b0;
  always @(negedge modulator_clock_i) begin
    bit_o <= level_i;
  end
endmodule
`default_nettype wire

/* verification/test_adc_conversion_control.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_consts.svh"
module test_adc_conversion_control;
  localparam int DIV = 2;              // Shortened oscillator divide
  logic                     clk_sys_i; // System clock
  logic                     rst_n_i;   // Active low reset
  logic                     start;     // One-shot request
  logic                     level;     // Modulator density
  logic                     mod_bit;   // Model bitstream
  logic                     busy;
  logic                     done;
  logic                     mclk;
  logic [15:0]              result;
  logic [2:0]               span;
  logic [2:0]               span2;     // Fixed variant span
  adcctl_pkg::adcctl_cfg_t   cfg;
  adcctl_pkg::adcctl_route_t route;
  adcctl_pkg::adcctl_route_t route2;   // Fixed variant routing
  int                       cyc, last_done, ivl, n_done;
  int                       last_mr, mper, fail_count, check_count;
  logic                     mclk_q;

  adcctl_top #(.OSC_DIV(DIV)) dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .cfg_i(cfg), .start_status_bit_i(start),
    .mod_bit_i(mod_bit), .result_o(result), .busy_o(busy), .done_o(done),
    .modulator_clock_o(mclk), .route_o(route), .full_scale_span_o(span));
  // Variant with no gain stage and no selector, sharing all inputs
  adcctl_top #(.HAS_GAIN(1'b0), .HAS_SEL(1'b0), .OSC_DIV(DIV)) dut_fixed (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
    .start_status_bit_i(start), .mod_bit_i(mod_bit), .result_o(),
    .busy_o(), .done_o(), .modulator_clock_o(), .route_o(route2),
    .full_scale_span_o(span2));
  adcctl_mod_model model (.modulator_clock_i(mclk), .level_i(level),
    .bit_o(mod_bit));

  // ----------------------------------------
  // Clock, monitor and timeout
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Completion spacing and modulator period, measured in system cycles;
  // sampled on the falling edge, clear of the edge that launches them
  always @(negedge clk_sys_i) begin
    cyc++;
    if (done === 1'b1) begin
      ivl = cyc - last_done;
      last_done = cyc;
      n_done++;
    end
    if (mclk === 1'b1 && mclk_q === 1'b0) begin
      mper = cyc - last_mr;
      last_mr = cyc;
    end
    mclk_q = mclk;
    // Whole run needs about 65000 cycles; beyond this something hangs
    if (cyc == 100000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic pulse_start();
    start = 1'b1;
    wait_cycles(1);
    start = 1'b0;
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Modulator clock period is four oscillator ticks
  task automatic t_mod_clock();
    wait_cycles(40);
    check(mper, 4 * DIV);
  endtask
  // Every input code and range code, both variants
  task automatic t_route_span();
    logic [2:0] s;
    for (int i = 0; i < 8; i++) begin
      s = i[2:0];
      cfg.input_select = s;
      cfg.range_select = s;
      wait_cycles(3);
      check(route.neg_gnd, s[2]);
      check(route.pos_sel, s[2] ? s[1:0] :
            ((s == 3'h3) ? 2'h2 : {1'b0, s == 3'h2}));
      if (!s[2]) check(route.neg_sel, (s == 3'h0) ? 2'h1 : 2'h3);
      check(route2, 5'h02);
      check(span, (s > 3'h5) ? 3'h5 : s);
      check(span2, 3'h2);
    end
  endtask
  // One-shot: one conversion per request, a late request is ignored
  task automatic t_one_shot(input logic lvl, input logic [15:0] code);
    int n0;
    level = lvl;
    cfg.one_shot = 1'b1;
    wait_cycles(60);
    check(busy, 1'b0);
    n0 = n_done;
    pulse_start();
    wait_cycles(100);
    pulse_start();
    for (int k = 0; k < 4000 && busy !== 1'b0; k++) wait_cycles(1);
    wait_cycles(4);
    check(n_done - n0, 1);
    check(busy, 1'b0);
    check(result, code);
    wait_cycles(200);
    check(result, code);
  endtask
  // One-shot at the 128 SPS code: start to completion spans one period
  task automatic t_slow_rate();
    int c0, n0, exp, dt;
    cfg.one_shot = 1'b1;
    cfg.rate_select = 3'h4;
    wait_cycles(4);
    n0 = n_done;
    c0 = cyc;
    pulse_start();
    for (int k = 0; k < 20000 && n_done == n0; k++) wait_cycles(1);
    exp = (`ADCCTL_OSC_HZ / `ADCCTL_SPS_4) * DIV;
    dt = cyc - c0;
    check(dt >= exp && dt <= exp + DIV + 4, 1'b1);
  endtask
  // Free running at the three fastest rates
  task automatic t_free_run();
    int sps_t[3];
    int exp, n0;
    sps_t = '{`ADCCTL_SPS_5, `ADCCTL_SPS_6, `ADCCTL_SPS_7};
    cfg.one_shot = 1'b0;
    for (int r = 0; r < 3; r++) begin
      cfg.rate_select = 3'(r + 5);
      exp = (`ADCCTL_OSC_HZ / sps_t[r]) * DIV;
      n0 = n_done;
      // First interval may straddle the rate change, so judge the third
      for (int k = 0; k < 30000 && n_done < n0 + 3; k++) wait_cycles(1);
      check(busy, 1'b1);
      check(ivl >= exp && ivl <= exp + DIV + 3, 1'b1);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    start = 1'b0;
    level = 1'b0;
    cfg = '{1'b1, 3'h0, 3'h2, 3'h7};
    wait_cycles(20);
    rst_n_i = 1'b1;
    t_mod_clock();
    t_route_span();
    t_one_shot(1'b1, 16'h7fff);
    t_one_shot(1'b0, 16'h8000);
    t_slow_rate();
    level = 1'b1;
    t_free_run();
    print_verdict();
  end
endmodule
`default_nettype wire
